// ---- verilog/cbrri_bus.sv ----
/*
 * Local bus cycle sequencer: multiplexed address/data, segment status,
 * byte select, read strobe with float, ready waits and maskable interrupt
 * sampling. Assumes i_ready already synchronous to i_clk and that the
 * execution unit flags the last cycle of each instruction.
 * Also assumes hold acknowledge is granted only between bus cycles: a hold
 * that lands inside a read forces the strobe high and cuts that read short.
 * A vector fetch after an accepted interrupt is an ordinary memory read that
 * the execution unit issues; this block does not build the table address.
 * The second acknowledge of a pair is a request with first_ack clear, so the
 * upper byte enable is only pulled low for the first one.
 */
`timescale 1ns/1ns
module cbrri_bus #(
	parameter int SYNC_N = cbrri_pkg::SYNC_STAGES
) (
	// Clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_resetn,
	// Execution unit side
	input  wire logic                          i_req_valid,
	input  wire cbrri_pkg::cbrri_req_type      i_req,
	input  wire logic                          i_last_instr_cycle,
	input  wire logic                          i_irq_enable,
	input  wire logic                          i_hold_ack,
	output logic                               o_req_ready,
	output logic                               o_rdata_valid,
	output logic [cbrri_pkg::BUS_W-1:0]        o_rdata,
	output logic                               o_irq_take,
	// Bus pins
	input  wire logic [cbrri_pkg::BUS_W-1:0]   i_muxed_addr_data_bus,
	output logic [cbrri_pkg::BUS_W-1:0]        o_muxed_addr_data_bus,
	output logic                               o_muxed_addr_data_bus_oe,
	output logic [3:0]                         o_addr_high,
	output cbrri_pkg::cbrri_status_type        o_status,
	output logic                               o_upper_byte_enable_n,
	output logic                               o_read_n,
	output logic                               o_read_n_oe,
	input  wire logic                          i_ready,
	input  wire logic                          i_maskable_irq
);
	import cbrri_pkg::*;

	cbrri_state_type   state_q;
	cbrri_req_type     req_q;
	logic [SYNC_N-1:0] irq_sync_q;
	logic              take;

	// Data phase ends at a t3 or wait state that sees ready high
	function automatic logic f_data_done(input cbrri_state_type st, input logic rdy);
		return (st == ST_T3 || st == ST_TW) && rdy;
	endfunction : f_data_done

	// Byte enable level of a request; the first acknowledge asks for the upper half
	function automatic logic f_upper_enable_n(input cbrri_req_type rq);
		if (rq.kind == CYC_INTA) begin
			return !rq.first_ack;
		end
		return !(rq.word || rq.addr[0]);
	endfunction : f_upper_enable_n

	// Taken only from idle and never under hold, so no cycle starts while hold is granted
	assign take = (state_q == ST_IDLE) && i_req_valid && !i_hold_ack;

	// Bus state sequence; waits inserted while ready reads low
	// No limit on waits: a device that never answers stalls the bus for good
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: if (take) state_q <= ST_T1;
				ST_T1:   state_q <= ST_T2;
				ST_T2:   state_q <= ST_T3;
				ST_T3:   state_q <= i_ready ? ST_T4 : ST_TW;
				ST_TW:   state_q <= i_ready ? ST_T4 : ST_TW;
				ST_T4:   state_q <= ST_IDLE;
			endcase
		end
	end

	// Request capture; a vector fetch is just a memory read issued upstream
	// Kept for the whole cycle so t2..t4 logic never looks at the live request
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			req_q <= '0;
		end else if (take) begin
			req_q <= i_req;
		end
	end

	// Accept handshake, one pulse per taken request
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_req_ready <= 1'b0;
		end else begin
			o_req_ready <= take && !o_req_ready;
		end
	end

	// Address in t1 except for acknowledges, write data t2..t4; read leaves lines released
	// Releasing in t2, on the same edge the strobe falls, lets the device drive the lines once the strobe is seen
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_muxed_addr_data_bus    <= '0;
			o_muxed_addr_data_bus_oe <= 1'b0;
			o_addr_high              <= '0;
		end else if (take) begin
			o_muxed_addr_data_bus    <= i_req.addr[BUS_W-1:0];
			o_muxed_addr_data_bus_oe <= (i_req.kind != CYC_INTA);
			o_addr_high              <= i_req.is_mem ? i_req.addr[ADDR_W-1:BUS_W] : 4'h0;
		end else if (state_q == ST_T1) begin
			o_muxed_addr_data_bus    <= req_q.wdata;
			o_muxed_addr_data_bus_oe <= (req_q.kind == CYC_WRITE);
			o_addr_high              <= '0;
		end else if (state_q == ST_T4 || state_q == ST_IDLE) begin
			o_muxed_addr_data_bus_oe <= 1'b0;
		end
	end

	// Segment status during t2..t4; memory/IO status for the whole cycle
	// Codes are held between cycles so the pins do not toggle while idle
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_status <= '0;
		end else if (state_q == ST_T1) begin
			o_status.segment_status_hi <= req_q.seg[1];
			o_status.segment_status_lo <= req_q.seg[0];
		end else if (take) begin
			o_status.mem_not_io <= i_req.is_mem;
		end
	end

	// Byte select: byte enable low for word or odd byte; low in first ack t1
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_upper_byte_enable_n <= 1'b1;
		end else if (take) begin
			o_upper_byte_enable_n <= f_upper_enable_n(i_req);
		end
	end

	// Read strobe low from t2 through waits; lines float already by then
	// Decided one edge ahead, so the t3 and wait terms look at ready now
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_read_n    <= 1'b1;
			o_read_n_oe <= 1'b1;
		end else begin
			o_read_n_oe <= !i_hold_ack;
			if (i_hold_ack) begin
				o_read_n <= 1'b1;
			end else if (req_q.kind == CYC_READ && (state_q == ST_T1 || state_q == ST_T2
				|| (state_q == ST_T3 && !i_ready) || (state_q == ST_TW && !i_ready))) begin
				o_read_n <= 1'b0;
			end else begin
				o_read_n <= 1'b1;
			end
		end
	end

	// Read data latched at the end of the last t3/tW
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_rdata       <= '0;
			o_rdata_valid <= 1'b0;
		end else begin
			o_rdata_valid <= (req_q.kind != CYC_WRITE) && f_data_done(state_q, i_ready);
			if (f_data_done(state_q, i_ready)) begin
				o_rdata <= i_muxed_addr_data_bus;
			end
		end
	end

	// Interrupt synchroniser; only the last stage is looked at
	// A deeper chain only delays acceptance, so the depth is a parameter
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			irq_sync_q <= '0;
		end else begin
			irq_sync_q <= {irq_sync_q[SYNC_N-2:0], i_maskable_irq};
		end
	end

	// Level sample at instruction end, masked by the enable flag
	// Sampling anywhere else would break into an instruction half done
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_irq_take <= 1'b0;
		end else begin
			o_irq_take <= i_last_instr_cycle && i_irq_enable
				&& irq_sync_q[SYNC_N-1];
		end
	end

endmodule : cbrri_bus

// ---- include/cbrri_pkg.sv ----
/*
 * Shared constants and types for the local bus cycle sequencer: bus state
 * codes, segment and byte-select encodings, request and pin carriers.
 * Assumes a single clock domain; no registers reachable by software.
 */
package cbrri_pkg;

	// Segment status codes shown in t2..t4
	localparam logic [1:0] SEG_ALT_DATA = 2'h0;
	localparam logic [1:0] SEG_STACK    = 2'h1;
	localparam logic [1:0] SEG_CODE     = 2'h2;
	localparam logic [1:0] SEG_DATA     = 2'h3;

	// Byte select codes {upper_byte_enable_n, lowest_address_bit}
	localparam logic [1:0] SEL_WORD  = 2'h0;
	localparam logic [1:0] SEL_UPPER = 2'h1;
	localparam logic [1:0] SEL_LOWER = 2'h2;
	localparam logic [1:0] SEL_NONE  = 2'h3;

	// Bus widths
	localparam int BUS_W  = 16;
	localparam int ADDR_W = 20;

	// Interrupt synchroniser depth
	localparam int SYNC_STAGES = 2;

	// Bus cycle states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_T1   = 6'h02,
		ST_T2   = 6'h04,
		ST_T3   = 6'h08,
		ST_TW   = 6'h10,
		ST_T4   = 6'h20
	} cbrri_state_type;

	// Kind of bus cycle
	typedef enum logic [1:0] {
		CYC_READ  = 2'h0,
		CYC_WRITE = 2'h1,
		CYC_INTA  = 2'h2
	} cbrri_cycle_type;

	// Request from the execution unit
	typedef struct packed {
		cbrri_cycle_type     kind;
		logic                is_mem;
		logic                word;
		logic [1:0]          seg;
		logic                first_ack;
		logic [ADDR_W-1:0]   addr;
		logic [BUS_W-1:0]    wdata;
	} cbrri_req_type;

	// Status pins shown to the bus
	typedef struct packed {
		logic                segment_status_hi;
		logic                segment_status_lo;
		logic                mem_not_io;
	} cbrri_status_type;

endpackage : cbrri_pkg

// ---- verif/cbrri_monitor.sv ----
/* Port checker bound onto the bus sequencer.
   Assumes one clock and a two-flop interrupt synchroniser. */
`timescale 1ns/1ns
module cbrri_monitor (
	// Design inputs
	input wire logic i_clk, i_resetn, i_last_instr_cycle, i_irq_enable, i_hold_ack, i_ready,
	input wire logic i_maskable_irq,
	input wire cbrri_pkg::cbrri_req_type i_req,
	// Design outputs
	input wire logic o_req_ready, o_rdata_valid, o_irq_take, o_upper_byte_enable_n, o_read_n,
	input wire logic o_read_n_oe, o_muxed_addr_data_bus_oe,
	input wire cbrri_pkg::cbrri_status_type o_status
);
	import cbrri_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// Read taken in t1, then strobe low only once the bus is let go
	sequence s_rd_t1; o_req_ready && i_req.kind == CYC_READ; endsequence
	sequence s_rd_t2; !o_read_n && !o_muxed_addr_data_bus_oe; endsequence
	a_read_strobe_t2: assert property (s_rd_t1 |=> s_rd_t2)
		else $error("strobe or bus release wrong in t2");
	a_byte_select: assert property (o_req_ready && i_req.kind != CYC_INTA |->
		o_upper_byte_enable_n == !(i_req.word || i_req.addr[0])) else $error("byte enable wrong");
	a_inta_upper: assert property (o_req_ready && i_req.kind == CYC_INTA && i_req.first_ack
		|-> !o_upper_byte_enable_n) else $error("byte enable high in first ack");
	a_seg_status: assert property (o_req_ready && i_req.kind != CYC_INTA |=>
		o_status == {$past(i_req.seg), $past(i_req.is_mem)}) else $error("status wrong in t2");
	// Waits keep the strobe low; the data pulse comes as the strobe ends
	a_wait_insert: assert property (!o_read_n && !i_ready |=> !o_read_n)
		else $error("strobe ended while ready low");
	a_read_length: assert property ($fell(o_read_n) |=> !o_read_n ##1 o_read_n == o_rdata_valid)
		else $error("strobe length or data pulse wrong");
	a_hold_float: assert property (i_hold_ack && o_read_n |=> o_read_n && !o_read_n_oe)
		else $error("strobe not floated high under hold");
	// Take needs the last cycle, the enable and a request three edges old
	a_irq_gate: assert property (o_irq_take |-> $past(i_last_instr_cycle) &&
		$past(i_irq_enable) && $past(i_maskable_irq, 3)) else $error("interrupt taken wrongly");
endmodule : cbrri_monitor

bind cbrri_bus cbrri_monitor cbrri_monitor_i (.*);

// ---- verif/cbrri_mem_model.sv ----
/* Device on the muxed bus answering reads after a set number of waits.
   Assumes no pull-ups, so a released bus shows a changing pattern. */
`timescale 1ns/1ns
module cbrri_mem_model (
	// Bus side
	input wire logic i_clk, i_read_n, i_bus_oe,
	input wire logic [15:0] i_bus,
	input wire logic [3:0] i_waits,
	output logic [15:0] o_bus,
	output logic o_ready
);
	logic [15:0] addr_q = 16'h0, last_q = 16'h0;
	logic oe_q = 1'b0;
	logic [3:0] cnt_q = 4'h0;
	// Address caught on the first driven cycle; write data is not an address
	always_ff @(posedge i_clk) begin
		oe_q <= i_bus_oe;
		last_q <= o_bus;
		addr_q <= (i_bus_oe && !oe_q) ? i_bus : addr_q;
		cnt_q <= i_read_n ? 4'h0 : cnt_q + 4'h1;
	end
	// Data only under the strobe, else the inverse of the last value
	assign o_bus = i_read_n ? ~last_q : addr_q ^ 16'hA5C3;
	// Clock-aligned ready, low for the first i_waits+1 strobe cycles, t2 included
	assign o_ready = i_read_n || (cnt_q > i_waits);
endmodule : cbrri_mem_model

// ---- verif/testbench.sv ----
/* Bench: sequencer with the device model; the checker binds itself.
   Assumes the device returns address xor A5C3. */
`timescale 1ns/1ns
module testbench;
	import cbrri_pkg::*;
	logic i_clk = 1'b0, i_resetn = 1'b0, i_req_valid = 1'b0, i_hold_ack = 1'b0, i_ready;
	logic i_last_instr_cycle = 1'b0, i_irq_enable = 1'b0, i_maskable_irq = 1'b0, o_read_n;
	logic o_req_ready, o_rdata_valid, o_irq_take, o_upper_byte_enable_n, o_read_n_oe;
	logic o_muxed_addr_data_bus_oe;
	logic [15:0] o_rdata, o_muxed_addr_data_bus, i_muxed_addr_data_bus;
	logic [3:0] waits = 4'h0;
	logic [3:0] o_addr_high;
	cbrri_req_type i_req = '0;
	cbrri_status_type o_status;
	int n_errors = 0, num_checks = 0;
	// Design and the device that answers it
	cbrri_bus cbrri_bus_i (.*, .o_addr_high(o_addr_high));
	cbrri_mem_model cbrri_mem_model_i (.i_clk, .i_read_n(o_read_n), .i_waits(waits),
		.i_bus_oe(o_muxed_addr_data_bus_oe), .i_bus(o_muxed_addr_data_bus),
		.o_bus(i_muxed_addr_data_bus), .o_ready(i_ready));
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	// One bus cycle; every wait is bounded and a timeout ends the run
	task automatic cyc(input cbrri_cycle_type k, input logic m, input logic wd,
		input logic [1:0] s, input logic [19:0] a, input logic [3:0] w, input logic fa);
		int n = 0;
		waits = w;
		i_req = '{k, m, wd, s, fa, a, 16'h5A5A};
		i_req_valid = 1'b1;
		while (!o_req_ready && n < 9) begin
			@(negedge i_clk);
			n++;
		end
		chk("taken", 1'b1, o_req_ready);
		if (n == 9) end_sim;
		chk("bhe", k == CYC_INTA ? !fa : !(wd | a[0]), o_upper_byte_enable_n);
		if (k != CYC_INTA) chk("addr", a[15:0], o_muxed_addr_data_bus);
		chk("addr hi", m ? a[19:16] : 4'h0, o_addr_high);
		i_req_valid = 1'b0;
		@(negedge i_clk);
		chk("strobe", k != CYC_READ, o_read_n);
		if (k == CYC_WRITE)
			chk("wdata", 20'h15A5A, {o_muxed_addr_data_bus_oe, o_muxed_addr_data_bus});
		if (k != CYC_INTA) chk("status", {s, m}, o_status);
		n = 0;
		while (k != CYC_WRITE && !o_rdata_valid && n < 12) begin
			@(negedge i_clk);
			n++;
		end
		if (k != CYC_WRITE) chk("waits", 20'(2 + w), 20'(n));
		if (k == CYC_READ) chk("rdata", a[15:0] ^ 16'hA5C3, o_rdata);
		if (n == 12) end_sim;
		repeat (3) @(negedge i_clk);
	endtask : cyc
	// All segment codes, both spaces, three byte selects, 0 to 3 waits
	task automatic t_reads;
		for (int s = 0; s < 4; s++) begin
			cyc(CYC_READ, s[1], s == 2, s[1:0], 20'hA1230 + 20'(s), 4'(s), 1'b1);
		end
	endtask : t_reads
	// A write keeps the strobe high; first ack drives the upper enable low, second not
	task automatic t_misc;
		cyc(CYC_WRITE, 1'b1, 1'b1, SEG_DATA, 20'h0BEE4, 4'h0, 1'b1);
		cyc(CYC_INTA, 1'b0, 1'b0, SEG_CODE, 20'h0, 4'h0, 1'b1);
		cyc(CYC_INTA, 1'b0, 1'b0, SEG_CODE, 20'h0, 4'h0, 1'b0);
	endtask : t_misc
	// Hold blocks the request and floats the strobe high
	task automatic t_hold;
		i_hold_ack = 1'b1;
		i_req_valid = 1'b1;
		repeat (4) @(negedge i_clk);
		chk("held", 1'b0, o_req_ready);
		chk("float", 2'h1, {o_read_n_oe, o_read_n});
		i_req_valid = 1'b0;
		@(negedge i_clk);
		i_hold_ack = 1'b0;
		@(negedge i_clk);
	endtask : t_hold
	// Synchroniser delay, then masking and the last-cycle window
	task automatic t_irq;
		i_irq_enable = 1'b1;
		i_last_instr_cycle = 1'b1;
		i_maskable_irq = 1'b1;
		@(negedge i_clk);
		chk("irq early", 1'b0, o_irq_take);
		repeat (2) @(negedge i_clk);
		chk("irq take", 1'b1, o_irq_take);
		i_irq_enable = 1'b0;
		repeat (2) @(negedge i_clk);
		chk("irq masked", 1'b0, o_irq_take);
		i_irq_enable = 1'b1;
		i_last_instr_cycle = 1'b0;
		repeat (2) @(negedge i_clk);
		chk("irq mid", 1'b0, o_irq_take);
	endtask : t_irq
	// 100 MHz clock
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// Two cycles of reset, then each scenario
	initial begin
		repeat (2) @(negedge i_clk);
		i_resetn = 1'b1;
		t_reads;
		t_misc;
		t_hold;
		t_irq;
		end_sim;
	end
endmodule : testbench
